/* File: rtl/csc_regs.vh */
`ifndef CSC_REGS_VH
`define CSC_REGS_VH
`define CSC_ADDR_STATUS      1'h0
`define CSC_ADDR_CONFIG      1'h1
`define CSC_ST_C             0
`define CSC_ST_Z             1
`define CSC_ST_OV            2
`define CSC_ST_N             3
`define CSC_ST_RA            4
`define CSC_ST_PRI_LO        5
`define CSC_ST_DC            8
`define CSC_ST_DA            9
`define CSC_ST_SAB           10
`define CSC_ST_OAB           11
`define CSC_ST_SB            12
`define CSC_ST_SA            13
`define CSC_ST_OB            14
`define CSC_ST_OA            15
`define CSC_CF_IF            0
`define CSC_CF_RND           1
`define CSC_CF_PSV           2
`define CSC_CF_PRI_HI        3
`define CSC_CF_ACCSEL        4
`define CSC_CF_STCLIP        5
`define CSC_CF_BCLIP         6
`define CSC_CF_ACLIP         7
`define CSC_CF_DEPTH         8
`define CSC_CF_EDT           11
`define CSC_CF_US            12
// Reset value of the eight stored config bits 7..0; store clip is on.
`define CSC_CFG_RESET        8'h20
`endif

/* File: rtl/csc_core_regs.v */
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "csc_regs.vh"
module csc_core_regs (
   input  wire        mclk_in,
   input  wire        rst_n_in,
   input  wire        addr_in,
   input  wire [15:0] wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [15:0] rdata_out,
   // ALU result port: one pulse per flag-affecting operation.
   input  wire        alu_upd_in,
   input  wire        alu_byte_in,
   input  wire        alu_sub_in,
   input  wire        alu_upd_z_in,
   input  wire [15:0] alu_opa_in,
   input  wire [15:0] alu_opb_in,
   // DSP adder port: one pulse per pass, per accumulator.
   input  wire        dsp_pass_a_in,
   input  wire        dsp_pass_b_in,
   input  wire [39:0] dsp_sum_in,
   input  wire        dsp_sat_in,
   input  wire        do_active_in,
   input  wire        rep_active_in,
   input  wire [2:0]  do_depth_in,
   input  wire        nesting_disable_in,
   // Interrupt controller may load the priority on entry and return.
   input  wire        pri_load_in,
   input  wire [3:0]  pri_value_in,
   output reg  [3:0]  cpu_priority_out,
   output reg         user_irq_block_out,
   output reg         do_early_exit_out,
   output reg         dsp_mul_unsigned_out,
   output reg         acc_a_clip_enable_out,
   output reg         acc_b_clip_enable_out,
   output reg         store_clip_enable_out,
   output reg         clip_width_select_out,
   output reg         program_window_enable_out,
   output reg         rounding_select_out,
   output reg         dsp_mul_integer_out
);

   reg        c_r, z_r, ov_r, n_r, dc_r;
   reg        oa_r, ob_r, sa_r, sb_r;
   reg [2:0]  pri_lo_r;
   reg        pri_hi_r;
   reg [7:0]  cfg_r;
   reg        us_r;
   reg        c_nxt, z_nxt, ov_nxt, n_nxt, dc_nxt;
   reg [16:0] sum;
   reg [15:0] opb;
   reg [4:0]  nib;
   reg [8:0]  byt;
   reg        cin, rsign, asign, bsign, ovf_g;
   wire [15:0] status_word;
   wire [15:0] config_word;
   wire        wr_st;
   wire        wr_cf;

   assign wr_st = wr_in && (addr_in == `CSC_ADDR_STATUS);
   assign wr_cf = wr_in && (addr_in == `CSC_ADDR_CONFIG);

   // Guard bits 39..31 not all equal means overflow into the guard bits.
   always @* begin
      ovf_g = ~((&dsp_sum_in[39:31]) | ~(|dsp_sum_in[39:31]));
   end

   // ALU flags: subtract adds the complement with carry in set, so the
   // carry flags come out as active-low borrows.
   always @* begin
      opb = alu_sub_in ? ~alu_opb_in : alu_opb_in;
      cin = alu_sub_in;
      sum = {1'b0, alu_opa_in} + {1'b0, opb} + {16'h0000, cin};
      nib = {1'b0, alu_opa_in[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
      byt = {1'b0, alu_opa_in[7:0]} + {1'b0, opb[7:0]} + {8'h00, cin};
      if (alu_byte_in) begin
         c_nxt = byt[8];
         dc_nxt = nib[4];
         rsign = byt[7];
         asign = alu_opa_in[7];
         bsign = opb[7];
         n_nxt = byt[7];
         z_nxt = (byt[7:0] == 8'h00);
      end else begin
         c_nxt = sum[16];
         dc_nxt = byt[8];
         rsign = sum[15];
         asign = alu_opa_in[15];
         bsign = opb[15];
         n_nxt = sum[15];
         z_nxt = (sum[15:0] == 16'h0000);
      end
      ov_nxt = (asign == bsign) && (rsign != asign);
   end

   // Status flags; a hardware update in the same cycle wins.
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         c_r <= 1'b0;
         z_r <= 1'b0;
         ov_r <= 1'b0;
         n_r <= 1'b0;
         dc_r <= 1'b0;
         oa_r <= 1'b0;
         ob_r <= 1'b0;
         sa_r <= 1'b0;
         sb_r <= 1'b0;
         pri_lo_r <= 3'h0;
         pri_hi_r <= 1'b0;
      end else begin
         if (alu_upd_in) begin
            c_r <= c_nxt;
            dc_r <= dc_nxt;
            n_r <= n_nxt;
            ov_r <= ov_nxt;
            // Zero only clears on non-zero; it may be set by plain ops.
            if (!z_nxt) begin
               z_r <= 1'b0;
            end else if (!alu_upd_z_in) begin
               z_r <= 1'b1;
            end
         end else if (wr_st) begin
            c_r <= wdata_in[`CSC_ST_C];
            z_r <= wdata_in[`CSC_ST_Z];
            ov_r <= wdata_in[`CSC_ST_OV];
            n_r <= wdata_in[`CSC_ST_N];
            dc_r <= wdata_in[`CSC_ST_DC];
         end
         if (dsp_pass_a_in) begin
            oa_r <= ovf_g;
         end
         if (dsp_pass_b_in) begin
            ob_r <= ovf_g;
         end
         // Sticky bits: set wins; a write of zero to either the own bit
         // or the combined bit clears, a write of one is ignored.
         if (dsp_pass_a_in && dsp_sat_in) begin
            sa_r <= 1'b1;
         end else if (wr_st && (!wdata_in[`CSC_ST_SA] ||
                                !wdata_in[`CSC_ST_SAB])) begin
            sa_r <= 1'b0;
         end
         if (dsp_pass_b_in && dsp_sat_in) begin
            sb_r <= 1'b1;
         end else if (wr_st && (!wdata_in[`CSC_ST_SB] ||
                                !wdata_in[`CSC_ST_SAB])) begin
            sb_r <= 1'b0;
         end
         if (pri_load_in) begin
            pri_lo_r <= pri_value_in[2:0];
            pri_hi_r <= pri_value_in[3];
         end else begin
            if (wr_st && !nesting_disable_in) begin
               pri_lo_r <= wdata_in[7:5];
            end
            if (wr_cf && !wdata_in[`CSC_CF_PRI_HI]) begin
               pri_hi_r <= 1'b0;
            end
         end
      end
   end

   // Configuration bits other than the depth, priority and exit strobe.
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_r <= `CSC_CFG_RESET;
         us_r <= 1'b0;
      end else if (wr_cf) begin
         cfg_r <= {wdata_in[7:4], 1'b0, wdata_in[2:0]};
         us_r <= wdata_in[`CSC_CF_US];
      end
   end

   assign status_word = {oa_r, ob_r, sa_r, sb_r, oa_r | ob_r,
                         sa_r | sb_r, do_active_in, dc_r,
                         pri_lo_r, rep_active_in,
                         n_r, ov_r, z_r, c_r};
   // Early exit bit is a write-only strobe and reads zero.
   assign config_word = {3'h0, us_r, 1'b0, do_depth_in,
                         cfg_r[7:4], pri_hi_r, cfg_r[2:0]};

   // Read data and registered outputs.
   always @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 16'h0000;
         cpu_priority_out <= 4'h0;
         user_irq_block_out <= 1'b0;
         do_early_exit_out <= 1'b0;
         dsp_mul_unsigned_out <= 1'b0;
         acc_a_clip_enable_out <= 1'b0;
         acc_b_clip_enable_out <= 1'b0;
         store_clip_enable_out <= 1'b1;
         clip_width_select_out <= 1'b0;
         program_window_enable_out <= 1'b0;
         rounding_select_out <= 1'b0;
         dsp_mul_integer_out <= 1'b0;
      end else begin
         rdata_out <= !rd_in ? 16'h0000 :
                      (addr_in == `CSC_ADDR_STATUS) ? status_word
                                                     : config_word;
         cpu_priority_out <= {pri_hi_r, pri_lo_r};
         user_irq_block_out <= pri_hi_r | (&pri_lo_r);
         do_early_exit_out <= wr_cf && wdata_in[`CSC_CF_EDT];
         dsp_mul_unsigned_out <= us_r;
         acc_a_clip_enable_out <= cfg_r[`CSC_CF_ACLIP];
         acc_b_clip_enable_out <= cfg_r[`CSC_CF_BCLIP];
         store_clip_enable_out <= cfg_r[`CSC_CF_STCLIP];
         clip_width_select_out <= cfg_r[`CSC_CF_ACCSEL];
         program_window_enable_out <= cfg_r[`CSC_CF_PSV];
         rounding_select_out <= cfg_r[`CSC_CF_RND];
         dsp_mul_integer_out <= cfg_r[`CSC_CF_IF];
      end
   end

endmodule

/* File: testbench/csc_core_chk.sv */
`timescale 1ns/10ps
module csc_core_chk (
   input wire        mclk_in,
   input wire        rst_n_in,
   input wire        addr_in,
   input wire [15:0] wdata_in,
   input wire        wr_in,
   input wire        rd_in,
   input wire [15:0] rdata_out,
   input wire        do_active_in,
   input wire        rep_active_in,
   input wire [2:0]  do_depth_in,
   input wire [3:0]  cpu_priority_out,
   input wire        user_irq_block_out,
   input wire        do_early_exit_out,
   input wire        dsp_mul_unsigned_out
);
   // One clock domain, so one clocking and one reset serve every check.
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   sequence cfg_wr; wr_in && addr_in; endsequence
   sequence st_rd; rd_in && !addr_in; endsequence
   sequence cf_rd; rd_in && addr_in; endsequence
   // Outputs trail the register by one cycle, hence the two-cycle lag.
   chk_mul_sign_out: assert property (cfg_wr |-> ##2
      dsp_mul_unsigned_out == $past(wdata_in[12], 2)) else $error("us lag");
   chk_exit_pulse: assert property (
      do_early_exit_out == $past(wr_in && addr_in && wdata_in[11]))
      else $error("early exit pulse");
   chk_exit_reads0: assert property (cf_rd |=> !rdata_out[11])
      else $error("early exit bit read back");
   chk_depth_live: assert property (cf_rd |=>
      rdata_out[10:8] == $past(do_depth_in) && rdata_out[15:13] == 3'h0)
      else $error("depth field");
   chk_loop_flags: assert property (st_rd |=>
      rdata_out[9] == $past(do_active_in) &&
      rdata_out[4] == $past(rep_active_in))
      else $error("loop flags");
   chk_ovf_or: assert property (st_rd |=>
      rdata_out[11] == (rdata_out[15] | rdata_out[14])) else $error("ovf or");
   chk_clip_or: assert property (st_rd |=>
      rdata_out[10] == (rdata_out[13] | rdata_out[12])) else $error("clip or");
   chk_irq_block: assert property (user_irq_block_out ==
      (cpu_priority_out[3] || &cpu_priority_out[2:0])) else $error("irq block");
endmodule
bind csc_core_regs csc_core_chk u_chk (.*);

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
   logic        mclk_in = 0, rst_n_in = 0, addr_in = 0, wr_in = 0, rd_in = 0;
   logic        alu_upd_in = 0, alu_byte_in = 0, alu_sub_in = 0;
   logic        alu_upd_z_in = 0, dsp_pass_a_in = 0, dsp_pass_b_in = 0;
   logic        dsp_sat_in = 0, do_active_in = 0, rep_active_in = 0;
   logic        nesting_disable_in = 0, pri_load_in = 0;
   logic [15:0] wdata_in = 0, alu_opa_in = 0, alu_opb_in = 0, rdata_out, v;
   logic [39:0] dsp_sum_in = 0;
   logic [2:0]  do_depth_in = 0;
   logic [3:0]  pri_value_in = 0, cpu_priority_out;
   logic        user_irq_block_out, do_early_exit_out;
   logic [7:0]  cfg_o;
   wire  [15:0] pri_o = {11'h0, user_irq_block_out, cpu_priority_out};
   int          err_count = 0, checks_done = 0;
   // Config outputs gathered in config-bit order 12,7,6,5,4,2,1,0.
   csc_core_regs u_dut (.*, .dsp_mul_unsigned_out(cfg_o[7]),
      .acc_a_clip_enable_out(cfg_o[6]), .acc_b_clip_enable_out(cfg_o[5]),
      .store_clip_enable_out(cfg_o[4]), .clip_width_select_out(cfg_o[3]),
      .program_window_enable_out(cfg_o[2]), .rounding_select_out(cfg_o[1]),
      .dsp_mul_integer_out(cfg_o[0]));
   always #4 mclk_in = ~mclk_in;
   task cmp(input string n, input [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input a, input [15:0] d);
      addr_in <= a; wdata_in <= d; wr_in <= 1;
      @(posedge mclk_in);
      wr_in <= 0;
      @(posedge mclk_in);
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task rd(input a);
      addr_in <= a; rd_in <= 1;
      @(posedge mclk_in);
      rd_in <= 0;
      #1 v = rdata_out;
      @(posedge mclk_in);
   endtask
   task alu(input [15:0] a, b, input byt, sub, z, input [15:0] e);
      alu_opa_in <= a; alu_opb_in <= b; alu_byte_in <= byt;
      alu_sub_in <= sub; alu_upd_z_in <= z; alu_upd_in <= 1;
      @(posedge mclk_in);
      alu_upd_in <= 0;
      rd(0);
      cmp("alu flags", e, v & 16'h010f);
   endtask
   task dsp(input pa, pb, sat, input [39:0] s);
      dsp_pass_a_in <= pa; dsp_pass_b_in <= pb; dsp_sat_in <= sat;
      dsp_sum_in <= s;
      @(posedge mclk_in);
      dsp_pass_a_in <= 0; dsp_pass_b_in <= 0;
      @(posedge mclk_in);
   endtask
   task t_reset;
      rd(1); cmp("config", 16'h0020, v);
      rd(0); cmp("status", 16'h0000, v);
      cmp("outs", 16'h0010, {8'h00, cfg_o});
      $display("t_reset done");
   endtask
   // Bit 3 can only be cleared and bit 11 never reads back.
   task t_config;
      do_depth_in <= 3'h5;
      wr(1, 16'hffff); rd(1);
      cmp("config", 16'h15f7, v);
      cmp("outs", 16'h00ff, {8'h00, cfg_o});
      wr(1, 16'h0000); rd(1);
      cmp("config", 16'h0500, v);
      cmp("outs", 16'h0000, {8'h00, cfg_o});
      $display("t_config done");
   endtask
   // A clear-only zero op keeps an earlier zero, then loses it.
   task t_alu;
      alu(16'hffff, 16'h0001, 0, 0, 0, 16'h0103);
      alu(16'h0000, 16'h0000, 0, 0, 1, 16'h0002);
      alu(16'h7fff, 16'h0001, 0, 0, 1, 16'h010c);
      alu(16'h000f, 16'h0001, 1, 0, 0, 16'h0100);
      alu(16'h0000, 16'h0001, 0, 1, 0, 16'h0008);
      $display("t_alu done");
   endtask
   task t_acc;
      dsp(1, 0, 1, 40'h0100000000);
      dsp(0, 1, 0, 40'h0000000000);
      rd(0); cmp("acc", 16'hac00, v & 16'hfc00);
      wr(0, 16'h3400); rd(0);
      cmp("acc", 16'hac00, v & 16'hfc00);
      wr(0, 16'h0000); rd(0);
      cmp("acc", 16'h8800, v & 16'hfc00);
      dsp(1, 0, 0, 40'h0000000000);
      do_active_in <= 1; rep_active_in <= 1;
      rd(0); cmp("acc", 16'h0210, v & 16'hfe10);
      $display("t_acc done");
   endtask
   task t_prio;
      wr(0, 16'h00e0); rd(0);
      cmp("prio", 16'h0017, pri_o);
      nesting_disable_in <= 1;
      wr(0, 16'h0020); rd(0);
      cmp("prio low", 16'h00e0, v & 16'h00e0);
      nesting_disable_in <= 0; pri_value_in <= 4'ha; pri_load_in <= 1;
      @(posedge mclk_in);
      pri_load_in <= 0;
      rd(1); cmp("prio hi", 16'h0008, v & 16'h0008);
      cmp("prio", 16'h001a, pri_o);
      wr(1, 16'h0000); rd(1);
      cmp("prio", 16'h0002, pri_o);
      $display("t_prio done");
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Reset for ten cycles, then run every scenario in turn.
   initial begin
      repeat (10) @(posedge mclk_in);
      rst_n_in <= 1;
      @(posedge mclk_in);
      t_reset; t_config; t_alu; t_acc; t_prio;
      tally_and_finish;
   end
   // The tests need well under a thousand cycles; this cuts a hang short.
   initial begin
      #40000;
      err_count++;
      tally_and_finish;
   end
endmodule
